// ===== pmg_pkg.sv
// constants and types for the module power and system management block
package pmg_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned SUS_WARN_NS     = 1000;
  localparam int unsigned SUS_WARN_CYC    = (SUS_WARN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RST_PULSE_NS    = 2000;
  localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W           = 8;
  // widths
  localparam int unsigned GP_W            = 4;
  localparam int unsigned SYNC_W          = 13;
  // synchroniser bit positions
  localparam int unsigned SB_POWER_BUTTON_N       = 0;
  localparam int unsigned SB_RSTBTN       = 1;
  localparam int unsigned SB_PWRGOOD      = 2;
  localparam int unsigned SB_PCIEWAKE     = 3;
  localparam int unsigned SB_GENWAKE      = 4;
  localparam int unsigned SB_BATTERY_LOW_N       = 5;
  localparam int unsigned SB_OVERTEMP     = 6;
  localparam int unsigned SB_ALERT        = 7;
  localparam int unsigned SB_KBDRST       = 8;
  localparam int unsigned SB_A20          = 9;
  localparam int unsigned SB_UNDERV       = 10;
  localparam int unsigned SB_WDOG         = 11;
  localparam int unsigned SB_TTRIP        = 12;
  // reset values
  localparam logic [GP_W-1:0]   GPO_RST     = 4'h0;
  // event lines (watchdog, undervoltage, trip, gate) idle low so reset makes no false event
  localparam logic [SYNC_W-1:0] SYNC_RST    = 13'h01FB;
  // power states
  typedef enum logic [2:0] {
    PMG_SOFT_OFF,
    PMG_POWER_UP,
    PMG_RUNNING,
    PMG_SUS_WARN,
    PMG_SLEEP_RAM
  } pmg_state_e;
endpackage

// ===== pmg_sync.sv
// two flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
module pmg_sync #(
  parameter int unsigned        W   = 1,
  parameter logic [W-1:0]       RST = '0
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  // data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pmg_sync_s;

  pmg_sync_s st_q;
  pmg_sync_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
    if (i_sys_rst) begin
      st_d.meta = RST;
      st_d.sync = RST;
    end
  end

  always_ff @(posedge i_core_clk) begin
    st_q <= st_d;
  end

  assign o_sync = st_q.sync;
endmodule

// ===== pmg_power_mgmt.sv
// power, reset and system management sequencer toward the carrier board
// Notes on behaviour
// - power button rising edge leaves soft off
// - reset button acts on falling edge only
// - carrier reset from button, power, undervoltage, watchdog, keyboard, software
// - power good high means main power good
// - suspend status asserted before suspend entry
// - sleep to ram indicator low while suspended
// - suspend to disk indicator unsupported, held high
// - soft off indicator asserted in soft off
// - first wake input is pcie wake
// - second wake input is general wake
// - over temperature input flags over temperature
// - thermal trip low after thermal shutdown
// - alert becomes management interrupt or wake
// - watchdog output shows watchdog timeout
// - four general outputs low after reset
// - four general inputs read high when undriven
// - firmware disable low selects off module firmware
// - keyboard reset low resets the system
// - keyboard gate drives address line 20 gate
// - beeper pin is sampled as strap at reset
`timescale 1ns/1ps
module pmg_power_mgmt #(
  parameter int unsigned GP_W       = pmg_pkg::GP_W,
  parameter int unsigned WARN_CYC   = pmg_pkg::SUS_WARN_CYC,
  parameter int unsigned RPULSE_CYC = pmg_pkg::RST_PULSE_CYC
) (
  // clock and reset
  input  wire logic            i_core_clk,
  input  wire logic            i_sys_rst,
  // buttons and supply
  input  wire logic            i_power_button_n,
  input  wire logic            i_reset_button_n,
  input  wire logic            i_power_good_in,
  input  wire logic            i_main_undervolt,
  // wake and status pins
  input  wire logic            i_pcie_wake_in_n,
  input  wire logic            i_general_wake_in_n,
  input  wire logic            i_battery_low_n,
  input  wire logic            i_over_temp_in_n,
  input  wire logic            i_mgmt_bus_alert_n,
  // legacy keyboard controller
  input  wire logic            i_keyboard_reset_n,
  input  wire logic            i_address_line20_gate,
  input  wire logic            i_firmware_disable_n,
  // processor side events
  input  wire logic            i_cpu_thermal_shutdown,
  input  wire logic            i_watchdog_timeout,
  // software side (same clock)
  input  wire logic            i_sw_reset_req,
  input  wire logic            i_sw_suspend_req,
  input  wire logic            i_sw_off_req,
  input  wire logic            i_alert_to_wake,
  input  wire logic [GP_W-1:0] i_gp_output_val,
  input  wire logic            i_beeper_val,
  // general purpose pins
  input  wire logic [GP_W-1:0] i_gp_input,
  output logic      [GP_W-1:0] o_gp_output,
  output logic      [GP_W-1:0] o_gp_input_sync,
  // beeper pin, strap during reset
  input  wire logic            i_beeper_pin,
  output logic                 o_beeper_out,
  output logic                 o_beeper_oe,
  output logic                 o_beeper_strap,
  // carrier side outputs
  output logic                 o_carrier_reset_out_n,
  output logic                 o_suspend_status_n,
  output logic                 o_sleep_ram_ind_n,
  output logic                 o_sleep_disk_ind_n,
  output logic                 o_soft_off_ind_n,
  output logic                 o_thermal_trip_out_n,
  output logic                 o_watchdog_event_out,
  // core side outputs
  output logic                 o_system_mgmt_interrupt,
  output logic                 o_over_temp,
  output logic                 o_battery_low,
  output logic                 o_wake_event,
  output logic                 o_address_line20_gate,
  output logic                 o_boot_external_fw,
  output logic                 o_main_power_en
);
  typedef struct packed {
    pmg_pkg::pmg_state_e             state;
    logic [pmg_pkg::CNT_W-1:0]       warn_cnt;
    logic [pmg_pkg::CNT_W-1:0]       rst_cnt;
    logic                            power_button_n_prev;
    logic                            rstbtn_prev;
    logic                            strap_taken;
    logic                            strap;
    logic                            boot_ext;
    logic                            alert_prev;
    logic                            wdog_seen;
    logic [GP_W-1:0]                 gp_output;
    logic [GP_W-1:0]                 gp_input;
    logic                            beeper;
    logic                            beeper_oe;
    logic                            carrier_rst_n;
    logic                            suspend_status_n_n;
    logic                            s3_n;
    logic                            s4_n;
    logic                            s5_n;
    logic                            ttrip_n;
    logic                            smi;
    logic                            over_temp;
    logic                            bat_low;
    logic                            wake;
    logic                            a20;
    logic                            main_en;
  } pmg_st_s;

  pmg_st_s st_q;
  pmg_st_s st_d;

  logic [pmg_pkg::SYNC_W-1:0] sync_in;
  logic [pmg_pkg::SYNC_W-1:0] sy;
  logic [GP_W-1:0]            gpi_sy;

  // every pin but the general inputs, firmware disable and beeper, including processor event lines, crosses in here
  assign sync_in = {i_cpu_thermal_shutdown, i_watchdog_timeout, i_main_undervolt,
                    i_address_line20_gate, i_keyboard_reset_n, i_mgmt_bus_alert_n,
                    i_over_temp_in_n, i_battery_low_n, i_general_wake_in_n,
                    i_pcie_wake_in_n, i_power_good_in, i_reset_button_n,
                    i_power_button_n};

  pmg_sync #(
    .W   (pmg_pkg::SYNC_W),
    .RST (pmg_pkg::SYNC_RST)
  ) u_sync_ctl (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    (sync_in),
    .o_sync     (sy)
  );

  // undriven inputs settle high through pull-ups, reset to high too
  pmg_sync #(
    .W   (GP_W),
    .RST ({GP_W{1'b1}})
  ) u_sync_gpi (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    (i_gp_input),
    .o_sync     (gpi_sy)
  );

  logic power_button_n_rise;
  logic rstbtn_fall;
  logic wake_any;
  logic alert_fall;
  logic reset_cause;

  always_comb begin
    power_button_n_rise = sy[pmg_pkg::SB_POWER_BUTTON_N] & ~st_q.power_button_n_prev;
    rstbtn_fall = ~sy[pmg_pkg::SB_RSTBTN] & st_q.rstbtn_prev;
    alert_fall  = ~sy[pmg_pkg::SB_ALERT] & st_q.alert_prev;
    wake_any    = ~sy[pmg_pkg::SB_PCIEWAKE]
                | ~sy[pmg_pkg::SB_GENWAKE]
                | (~sy[pmg_pkg::SB_ALERT] & i_alert_to_wake)
                | power_button_n_rise;
    // level causes hold reset; the button only fires a pulse
    reset_cause = rstbtn_fall
                | ~sy[pmg_pkg::SB_PWRGOOD]
                | sy[pmg_pkg::SB_UNDERV]
                | sy[pmg_pkg::SB_WDOG]
                | i_sw_reset_req
                | ~sy[pmg_pkg::SB_KBDRST];
  end

  always_comb begin
    st_d             = st_q;
    st_d.power_button_n_prev = sy[pmg_pkg::SB_POWER_BUTTON_N];
    st_d.rstbtn_prev = sy[pmg_pkg::SB_RSTBTN];
    st_d.alert_prev  = sy[pmg_pkg::SB_ALERT];
    st_d.gp_input         = gpi_sy;
    st_d.over_temp   = ~sy[pmg_pkg::SB_OVERTEMP];
    st_d.bat_low     = ~sy[pmg_pkg::SB_BATTERY_LOW_N];
    st_d.a20         = sy[pmg_pkg::SB_A20];
    st_d.smi         = alert_fall & ~i_alert_to_wake;
    st_d.wake        = 1'b0;
    st_d.s4_n        = 1'b1;
    st_d.wdog_seen   = sy[pmg_pkg::SB_WDOG];
    // thermal trip latches until the next hardware reset
    if (sy[pmg_pkg::SB_TTRIP]) begin
      st_d.ttrip_n = 1'b0;
    end

    // strap taken on the first cycle after reset release
    if (!st_q.strap_taken) begin
      st_d.strap_taken = 1'b1;
      st_d.strap       = i_beeper_pin;
      st_d.boot_ext    = ~i_firmware_disable_n;
      st_d.beeper_oe   = 1'b1;
    end
    st_d.beeper = i_beeper_val & st_q.strap_taken;
    st_d.gp_output    = i_gp_output_val;

    // carrier reset pulse stretcher, lengthened while a level cause holds
    if (reset_cause && st_q.state != pmg_pkg::PMG_SOFT_OFF) begin
      st_d.rst_cnt       = pmg_pkg::CNT_W'(RPULSE_CYC);
      st_d.carrier_rst_n = 1'b0;
    end else if (st_q.rst_cnt != '0) begin
      st_d.rst_cnt = st_q.rst_cnt - pmg_pkg::CNT_W'(1);
    end else begin
      st_d.carrier_rst_n = (st_q.state == pmg_pkg::PMG_RUNNING);
    end

    case (st_q.state)
      pmg_pkg::PMG_SOFT_OFF: begin
        st_d.main_en = 1'b0;
        if (power_button_n_rise) begin
          st_d.state   = pmg_pkg::PMG_POWER_UP;
          st_d.s5_n    = 1'b1;
          st_d.s3_n    = 1'b1;
          st_d.main_en = 1'b1;
        end
      end
      pmg_pkg::PMG_POWER_UP: begin
        // held in reset until the supply reports good
        if (sy[pmg_pkg::SB_PWRGOOD]) begin
          st_d.state   = pmg_pkg::PMG_RUNNING;
          st_d.rst_cnt = pmg_pkg::CNT_W'(RPULSE_CYC);
        end
      end
      pmg_pkg::PMG_RUNNING: begin
        if (i_sw_off_req) begin
          st_d.state         = pmg_pkg::PMG_SOFT_OFF;
          st_d.s5_n          = 1'b0;
          st_d.s3_n          = 1'b0;
          st_d.main_en       = 1'b0;
          st_d.carrier_rst_n = 1'b0;
        end else if (i_sw_suspend_req) begin
          st_d.state      = pmg_pkg::PMG_SUS_WARN;
          st_d.suspend_status_n_n = 1'b0;
          st_d.warn_cnt   = pmg_pkg::CNT_W'(WARN_CYC);
        end
      end
      pmg_pkg::PMG_SUS_WARN: begin
        // peripherals get a warning window before power drops
        if (st_q.warn_cnt > pmg_pkg::CNT_W'(1)) begin
          st_d.warn_cnt = st_q.warn_cnt - pmg_pkg::CNT_W'(1);
        end else begin
          st_d.state         = pmg_pkg::PMG_SLEEP_RAM;
          st_d.s3_n          = 1'b0;
          st_d.main_en       = 1'b0;
          st_d.carrier_rst_n = 1'b0;
        end
      end
      pmg_pkg::PMG_SLEEP_RAM: begin
        if (wake_any) begin
          st_d.state      = pmg_pkg::PMG_POWER_UP;
          st_d.s3_n       = 1'b1;
          st_d.suspend_status_n_n = 1'b1;
          st_d.main_en    = 1'b1;
          st_d.wake       = 1'b1;
        end
      end
      default: begin
        st_d.state = pmg_pkg::PMG_SOFT_OFF;
      end
    endcase

    if (i_sys_rst) begin
      st_d.state         = pmg_pkg::PMG_SOFT_OFF;
      st_d.warn_cnt      = '0;
      st_d.rst_cnt       = '0;
      st_d.power_button_n_prev   = 1'b1;
      st_d.rstbtn_prev   = 1'b1;
      st_d.alert_prev    = 1'b1;
      st_d.strap_taken   = 1'b0;
      st_d.strap         = 1'b0;
      st_d.boot_ext      = 1'b0;
      st_d.wdog_seen     = 1'b0;
      st_d.gp_output           = pmg_pkg::GPO_RST;
      st_d.gp_input           = {GP_W{1'b1}};
      st_d.beeper        = 1'b0;
      st_d.beeper_oe     = 1'b0;
      st_d.carrier_rst_n = 1'b0;
      st_d.suspend_status_n_n    = 1'b1;
      st_d.s3_n          = 1'b0;
      st_d.s5_n          = 1'b0;
      st_d.ttrip_n       = 1'b1;
      st_d.smi           = 1'b0;
      st_d.over_temp     = 1'b0;
      st_d.bat_low       = 1'b0;
      st_d.wake          = 1'b0;
      st_d.a20           = 1'b0;
      st_d.main_en       = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    st_q <= st_d;
  end

  assign o_gp_output             = st_q.gp_output;
  assign o_gp_input_sync         = st_q.gp_input;
  assign o_beeper_out            = st_q.beeper;
  assign o_beeper_oe             = st_q.beeper_oe;
  assign o_beeper_strap          = st_q.strap;
  assign o_carrier_reset_out_n   = st_q.carrier_rst_n;
  assign o_suspend_status_n      = st_q.suspend_status_n_n;
  assign o_sleep_ram_ind_n       = st_q.s3_n;
  // disk suspend is not offered, so the pin idles inactive
  assign o_sleep_disk_ind_n      = st_q.s4_n;
  assign o_soft_off_ind_n        = st_q.s5_n;
  assign o_thermal_trip_out_n    = st_q.ttrip_n;
  assign o_watchdog_event_out    = st_q.wdog_seen;
  assign o_system_mgmt_interrupt = st_q.smi;
  assign o_over_temp             = st_q.over_temp;
  assign o_battery_low           = st_q.bat_low;
  assign o_wake_event            = st_q.wake;
  assign o_address_line20_gate   = st_q.a20;
  assign o_boot_external_fw      = st_q.boot_ext;
  assign o_main_power_en         = st_q.main_en;
endmodule

// ===== pmg_power_mgmt_monitor.sv
// checker watching the power management block ports
`timescale 1ns/1ps
module pmg_power_mgmt_monitor #(
  parameter int unsigned GP_W = pmg_pkg::GP_W
) (
  // clock and reset
  input wire logic            i_core_clk,
  input wire logic            i_sys_rst,
  // watched inputs
  input wire logic            i_reset_button_n,
  input wire logic            i_mgmt_bus_alert_n,
  input wire logic            i_alert_to_wake,
  input wire logic            i_cpu_thermal_shutdown,
  input wire logic            i_watchdog_timeout,
  input wire logic [GP_W-1:0] i_gp_output_val,
  // watched outputs
  input wire logic [GP_W-1:0] o_gp_output,
  input wire logic            o_carrier_reset_out_n,
  input wire logic            o_suspend_status_n,
  input wire logic            o_sleep_ram_ind_n,
  input wire logic            o_sleep_disk_ind_n,
  input wire logic            o_soft_off_ind_n,
  input wire logic            o_thermal_trip_out_n,
  input wire logic            o_watchdog_event_out,
  input wire logic            o_system_mgmt_interrupt
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  property p_disk_high;
    o_sleep_disk_ind_n;
  endproperty
  a_disk_high: assert property (p_disk_high) else $error("disk ind low");
  property p_reset_button;
    $fell(i_reset_button_n) && o_carrier_reset_out_n |-> ##[2:5] !o_carrier_reset_out_n;
  endproperty
  a_reset_button: assert property (p_reset_button) else $error("no button reset");
  property p_soft_off;
    !o_soft_off_ind_n |-> !o_carrier_reset_out_n;
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("reset free in soft off");
  property p_sleep_ram;
    !o_sleep_ram_ind_n && o_soft_off_ind_n |-> !o_suspend_status_n;
  endproperty
  a_sleep_ram: assert property (p_sleep_ram) else $error("sleep without status");
  property p_sus_warn;
    $fell(o_sleep_ram_ind_n) && o_soft_off_ind_n |-> $past(o_suspend_status_n, 2) == 1'b0;
  endproperty
  a_sus_warn: assert property (p_sus_warn) else $error("sleep without warning");
  property p_thermal;
    $rose(i_cpu_thermal_shutdown) |-> ##[2:4] !o_thermal_trip_out_n;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal trip late");
  property p_watchdog;
    $rose(i_watchdog_timeout) |-> ##[2:4] o_watchdog_event_out;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog out late");
  property p_gp_out;
    o_gp_output == ($past(i_sys_rst) ? '0 : $past(i_gp_output_val));
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("gp output wrong");
  property p_mgmt_int;
    $fell(i_mgmt_bus_alert_n) && !i_alert_to_wake |-> ##[2:4] o_system_mgmt_interrupt;
  endproperty
  a_mgmt_int: assert property (p_mgmt_int) else $error("no mgmt interrupt");
endmodule

bind pmg_power_mgmt pmg_power_mgmt_monitor #(.GP_W(GP_W)) i_pmg_power_mgmt_monitor (
  .i_core_clk, .i_sys_rst, .i_reset_button_n, .i_mgmt_bus_alert_n, .i_alert_to_wake,
  .i_cpu_thermal_shutdown, .i_watchdog_timeout, .i_gp_output_val, .o_gp_output,
  .o_carrier_reset_out_n, .o_suspend_status_n, .o_sleep_ram_ind_n, .o_sleep_disk_ind_n,
  .o_soft_off_ind_n, .o_thermal_trip_out_n, .o_watchdog_event_out, .o_system_mgmt_interrupt
);

// ===== pmg_carrier_model.sv
// carrier board model: main supply, pin pull-ups, beeper strap
`timescale 1ns/1ps
module pmg_carrier_model (
  // clock
  input  wire logic       i_core_clk,
  // controls
  input  wire logic       i_main_power_en,
  input  wire logic       i_slow,
  input  wire logic       i_fail,
  input  wire logic [3:0] i_gp_drive,
  input  wire logic       i_beeper_out,
  input  wire logic       i_beeper_oe,
  // pins toward the module
  output logic            o_power_good_in = 1'b0,
  output logic      [3:0] o_gp_pin,
  output logic            o_beeper_pin
);
  logic [3:0] ramp_q = 4'h0;
  // slow ramp makes the module wait for good power
  always @(posedge i_core_clk) begin
    if (!i_main_power_en || i_fail) begin
      ramp_q <= 4'h0;
    end else if (ramp_q != 4'hF) begin
      ramp_q <= ramp_q + 4'h1;
    end
    o_power_good_in <= !i_fail && i_main_power_en && ramp_q >= (i_slow ? 4'hC : 4'h2);
  end
  // undriven pins float to the pull-up
  assign o_gp_pin = ~i_gp_drive;
  // no load on the beeper, strap reads the pull-up
  assign o_beeper_pin = i_beeper_oe ? i_beeper_out : 1'b1;
endmodule

// ===== pmg_power_mgmt_tb.sv
// self-checking bench for the power management block
`timescale 1ns/1ps
module pmg_power_mgmt_tb;
  logic i_core_clk, i_sys_rst, i_power_button_n, i_reset_button_n, i_power_good_in;
  logic i_main_undervolt, i_pcie_wake_in_n, i_general_wake_in_n, i_battery_low_n;
  logic i_over_temp_in_n, i_mgmt_bus_alert_n, i_keyboard_reset_n, i_address_line20_gate;
  logic i_firmware_disable_n, i_cpu_thermal_shutdown, i_watchdog_timeout, i_sw_reset_req;
  logic i_sw_suspend_req, i_sw_off_req, i_alert_to_wake, i_beeper_val, i_beeper_pin;
  logic [3:0] i_gp_output_val, i_gp_input, gp_drive, o_gp_output, o_gp_input_sync;
  logic o_beeper_out, o_beeper_oe, o_beeper_strap, o_carrier_reset_out_n, o_suspend_status_n;
  logic o_sleep_ram_ind_n, o_sleep_disk_ind_n, o_soft_off_ind_n, o_thermal_trip_out_n;
  logic o_watchdog_event_out, o_system_mgmt_interrupt, o_over_temp, o_battery_low;
  logic o_wake_event, o_address_line20_gate, o_boot_external_fw, o_main_power_en, slow, fail;
  int checks = 0;
  int bad_count = 0;
  int cyc = 0;
  // short counts keep the run brief
  pmg_power_mgmt #(.WARN_CYC(4), .RPULSE_CYC(4)) i_pmg_power_mgmt (
    .i_core_clk, .i_sys_rst, .i_power_button_n, .i_reset_button_n, .i_power_good_in,
    .i_main_undervolt, .i_pcie_wake_in_n, .i_general_wake_in_n, .i_battery_low_n,
    .i_over_temp_in_n, .i_mgmt_bus_alert_n, .i_keyboard_reset_n, .i_address_line20_gate,
    .i_firmware_disable_n, .i_cpu_thermal_shutdown, .i_watchdog_timeout, .i_sw_reset_req,
    .i_sw_suspend_req, .i_sw_off_req, .i_alert_to_wake, .i_gp_output_val, .i_beeper_val,
    .i_gp_input, .o_gp_output, .o_gp_input_sync, .i_beeper_pin, .o_beeper_out, .o_beeper_oe,
    .o_beeper_strap, .o_carrier_reset_out_n, .o_suspend_status_n, .o_sleep_ram_ind_n,
    .o_sleep_disk_ind_n, .o_soft_off_ind_n, .o_thermal_trip_out_n, .o_watchdog_event_out,
    .o_system_mgmt_interrupt, .o_over_temp, .o_battery_low, .o_wake_event,
    .o_address_line20_gate, .o_boot_external_fw, .o_main_power_en);
  pmg_carrier_model i_pmg_carrier_model (.i_core_clk, .i_main_power_en(o_main_power_en),
    .i_slow(slow), .i_fail(fail), .i_gp_drive(gp_drive), .i_beeper_out(o_beeper_out),
    .i_beeper_oe(o_beeper_oe), .o_power_good_in(i_power_good_in), .o_gp_pin(i_gp_input),
    .o_beeper_pin(i_beeper_pin));
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      test_done;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #10;
  endtask
  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return o_carrier_reset_out_n;
      1: return o_sleep_ram_ind_n;
      2: return o_wake_event;
      default: return o_system_mgmt_interrupt;
    endcase
  endfunction
  // bounded wait, then one compare of the awaited level
  task automatic wait_for(input int s, input logic lvl, input string name);
    int n;
    n = 0;
    while (pick(s) !== lvl && n < 80) begin
      step(1);
      n++;
    end
    chk(name, pick(s), lvl);
  endtask
  task automatic set_cause(input int i, input logic on);
    case (i)
      0: i_main_undervolt = on;
      1: i_keyboard_reset_n = !on;
      2: i_watchdog_timeout = on;
      3: i_sw_reset_req = on;
      default: fail = on;
    endcase
  endtask
  task automatic t_power_up;
    i_power_button_n = 1'b0;
    step(3);
    i_power_button_n = 1'b1;
    step(5);
    chk("leave soft off", {o_soft_off_ind_n, o_main_power_en}, 2'h3);
    wait_for(0, 1'b1, "reset after power good");
    $display("power up done");
  endtask
  task automatic t_reset_btn;
    i_reset_button_n = 1'b0;
    wait_for(0, 1'b0, "reset by button");
    wait_for(0, 1'b1, "release while held");
    step(10);
    chk("held button", o_carrier_reset_out_n, 1'b1);
    i_reset_button_n = 1'b1;
    step(10);
    chk("button rise", o_carrier_reset_out_n, 1'b1);
    $display("reset button done");
  endtask
  task automatic t_causes;
    for (int i = 0; i < 5; i++) begin
      set_cause(i, 1'b1);
      wait_for(0, 1'b0, "reset by cause");
      step(8);
      chk("reset held", o_carrier_reset_out_n, 1'b0);
      if (i == 2) chk("watchdog out", o_watchdog_event_out, 1'b1);
      set_cause(i, 1'b0);
      wait_for(0, 1'b1, "reset released");
    end
    $display("reset causes done");
  endtask
  task automatic t_suspend;
    i_alert_to_wake = 1'b1;
    for (int w = 0; w < 3; w++) begin
      slow = (w == 1);
      i_sw_suspend_req = 1'b1;
      step(1);
      i_sw_suspend_req = 1'b0;
      step(1);
      chk("warning", {o_suspend_status_n, o_sleep_ram_ind_n}, 2'h1);
      wait_for(1, 1'b0, "sleep ram ind");
      step(3);
      chk("asleep", {o_sleep_ram_ind_n, o_carrier_reset_out_n, o_main_power_en}, 3'h0);
      case (w)
        0: i_pcie_wake_in_n = 1'b0;
        1: i_general_wake_in_n = 1'b0;
        default: i_mgmt_bus_alert_n = 1'b0;
      endcase
      wait_for(2, 1'b1, "wake event");
      step(4);
      {i_pcie_wake_in_n, i_general_wake_in_n, i_mgmt_bus_alert_n} = 3'h7;
      chk("awake", {o_sleep_ram_ind_n, o_main_power_en}, 2'h3);
      wait_for(0, 1'b1, "reset after wake");
    end
    i_alert_to_wake = 1'b0;
    step(5);
    $display("suspend and wake done");
  endtask
  task automatic t_misc;
    {i_battery_low_n, i_over_temp_in_n, i_mgmt_bus_alert_n} = 3'h0;
    {i_address_line20_gate, i_beeper_val, i_gp_output_val, gp_drive} = 10'h3C5;
    wait_for(3, 1'b1, "mgmt interrupt");
    step(4);
    chk("low battery and heat", {o_battery_low, o_over_temp}, 2'h3);
    chk("gate and beeper", {o_address_line20_gate, o_beeper_out, o_beeper_oe}, 3'h7);
    chk("gp input", o_gp_input_sync, 4'hA);
    chk("gp output", o_gp_output, 4'hC);
    i_cpu_thermal_shutdown = 1'b1;
    step(5);
    i_cpu_thermal_shutdown = 1'b0;
    step(5);
    chk("thermal trip", o_thermal_trip_out_n, 1'b0);
    $display("status pins done");
  endtask
  task automatic t_soft_off;
    i_sw_off_req = 1'b1;
    step(1);
    i_sw_off_req = 1'b0;
    step(1);
    chk("soft off", {o_soft_off_ind_n, o_sleep_ram_ind_n, o_main_power_en,
        o_carrier_reset_out_n}, 4'h0);
    $display("soft off done");
  endtask
  initial begin
    {i_sys_rst, i_power_button_n, i_reset_button_n, i_pcie_wake_in_n, i_general_wake_in_n,
     i_battery_low_n, i_over_temp_in_n, i_mgmt_bus_alert_n, i_keyboard_reset_n} = 9'h1FF;
    {i_main_undervolt, i_address_line20_gate, i_firmware_disable_n, i_cpu_thermal_shutdown,
     i_watchdog_timeout, i_sw_reset_req, i_sw_suspend_req, i_sw_off_req, i_alert_to_wake,
     i_beeper_val, slow, fail} = 12'h000;
    {i_gp_output_val, gp_drive} = 8'hF0;
    step(3);
    chk("strap drive", o_beeper_oe, 1'b0);
    chk("gp output in reset", o_gp_output, 4'h0);
    i_gp_output_val = 4'h0;
    step(2);
    i_sys_rst = 1'b0;
    step(3);
    chk("off state", {o_soft_off_ind_n, o_carrier_reset_out_n, o_main_power_en}, 3'h0);
    chk("idle levels", {o_sleep_disk_ind_n, o_thermal_trip_out_n}, 2'h3);
    chk("gp output", o_gp_output, 4'h0);
    chk("gp input", o_gp_input_sync, 4'hF);
    chk("straps", {o_boot_external_fw, o_beeper_strap}, 2'h3);
    $display("reset values done");
    t_power_up;
    t_reset_btn;
    t_causes;
    t_suspend;
    t_misc;
    t_soft_off;
    test_done;
  end
endmodule
